//--- verification/tb.sv
// Self-checking bench: host controller and touch sensor joined by the link
`timescale 1ns/10ps
module tb;
  logic i_clk_sys = 1'b0;
  logic i_rst_b = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] rdata;
  logic irq;
  logic [13:0] sense = 14'h0000;
  logic [13:0] flags;
  logic [2:0] dsel;
  logic osc;
  logic in_rst;
  logic [7:0] exp_q[$];
  logic [7:0] exp_v;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  int seed = 70;
  tsh_link_if link ();
  tsh_host #(.QTR_CYC(8)) i_tsh_host (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .link(link.host),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq));
  tsh_dev i_tsh_dev (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .link(link.dev),
    .i_sense_channel_inputs(sense), .o_channel_touch_flag(flags), .o_device_select_bits(dsel),
    .o_osc_run(osc), .o_in_reset(in_rst));
  tsh_link_chk i_tsh_link_chk (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .host_sda_oe(link.host_sda_oe), .host_rst_oe(link.host_rst_oe),
    .dev_sda_oe(link.dev_sda_oe), .dev_int_oe(link.dev_int_oe), .scl(link.scl),
    .sda(link.sda), .int_n(link.int_n), .rst_pin_n(link.rst_pin_n));
  always #5 i_clk_sys = !i_clk_sys;
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Read data is due the cycle after the strobe, so compare from the queue there
  always @(posedge i_clk_sys)
  begin
    if (rd_d)
    begin
      exp_v = exp_q.pop_front();
      cmp(rdata, exp_v);
    end
    rd_d <= rd;
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      fails++;
      end_sim();
    end
  end
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clk_sys);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge i_clk_sys);
    rd <= 1'b0;
  endtask
  task automatic wait_irq();
    for (int n = 0; n < 5000 && irq !== 1'b1; n++) @(negedge i_clk_sys);
    cmp(irq, 1'b1);
    wr_reg(4'h6, 8'h07);
  endtask
  task automatic dev_wr(input logic [7:0] p, input logic [7:0] d);
    wr_reg(4'h0, p);
    wr_reg(4'h1, d);
    wr_reg(4'h2, 8'h01);
    // Sample only with the clock line low: both lines high stops the oscillator
    for (int k = 0; k < 200 && link.scl; k++) @(negedge i_clk_sys);
    repeat (6) @(negedge i_clk_sys);
    cmp(osc, 1'b1);
    wait_irq();
  endtask
  task automatic dev_rd(input logic [7:0] p, input logic [7:0] e);
    wr_reg(4'h0, p);
    wr_reg(4'h2, 8'h02);
    wait_irq();
    rd_reg(4'h4, e);
  endtask
  initial
  begin
    link.opt_pin <= 1'b1;
    repeat (10) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    repeat (12) @(posedge i_clk_sys);
    cmp(dsel, 3'h3);
    cmp(osc, 1'b0);
    wr_reg(4'h7, 8'h01);
    wr_reg(4'h8, 8'h03);
    rd_reg(4'h9, 8'h00);
    dev_rd(8'h01, 8'hb6);
    dev_wr(8'h0f, 8'h5a);
    dev_rd(8'h0f, 8'h5a);
    // Bus idle again after the stop, so the oscillator must be parked
    cmp(osc, 1'b0);
    dev_rd(8'h05, 8'h3f);
    dev_rd(8'h06, 8'hff);
    dev_wr(8'h21, 8'h03);
    dev_wr(8'h22, 8'h01);
    sense <= 14'($random(seed)) | 14'h0001;
    repeat (20) @(posedge i_clk_sys);
    cmp(flags, sense);
    cmp(link.int_n, 1'b0);
    rd_reg(4'h5, 8'h04);
    wr_reg(4'h7, 8'h05);
    repeat (3) @(negedge i_clk_sys);
    cmp(irq, 1'b1);
    wr_reg(4'h7, 8'h01);
    repeat (3) @(negedge i_clk_sys);
    cmp(irq, 1'b0);
    wr_reg(4'h6, 8'h04);
    dev_rd(8'h02, sense[7:0]);
    dev_rd(8'h03, {2'b00, sense[13:8]});
    dev_rd(8'h20, 8'h01);
    dev_wr(8'h21, 8'h01);
    cmp(link.int_n, 1'b1);
    dev_wr(8'h10, 8'h00);
    dev_rd(8'h10, 8'h00);
    sense <= ~sense;
    repeat (30) @(posedge i_clk_sys);
    cmp(link.int_n, 1'b0);
    repeat (120) @(posedge i_clk_sys);
    cmp(link.int_n, 1'b1);
    wr_reg(4'h8, 8'h00);
    dev_wr(8'h22, 8'h00);
    rd_reg(4'h3, 8'h06);
    wr_reg(4'h8, 8'h03);
    wr_reg(4'h2, 8'h04);
    repeat (20) @(negedge i_clk_sys);
    cmp(in_rst, 1'b1);
    repeat (1100) @(negedge i_clk_sys);
    cmp(in_rst, 1'b0);
    dev_rd(8'h22, 8'h00);
    i_rst_b <= 1'b0;
    link.opt_pin <= 1'b0;
    repeat (10) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    repeat (12) @(posedge i_clk_sys);
    cmp(dsel, 3'h0);
    link.opt_pin <= 1'b1;
    repeat (20) @(posedge i_clk_sys);
    cmp(dsel, 3'h0);
    wr_reg(4'h7, 8'h01);
    wr_reg(4'h8, 8'h00);
    dev_rd(8'h01, 8'hb0);
    end_sim();
  end
endmodule

//--- verification/tsh_link_chk.sv
// Pin level checks on the link between host controller and touch sensor
`timescale 1ns/10ps
`include "tsh_defs.svh"
module tsh_link_chk (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic host_sda_oe,
  input wire logic host_rst_oe,
  input wire logic dev_sda_oe,
  input wire logic dev_int_oe,
  input wire logic scl,
  input wire logic sda,
  input wire logic int_n,
  input wire logic rst_pin_n
);
  // Wide counters so a long level interrupt cannot wrap within a run
  logic [15:0] rst_len;
  logic [15:0] next_rst_len;
  logic [15:0] int_len;
  logic [15:0] next_int_len;
  always_comb
  begin
    next_rst_len = host_rst_oe ? rst_len + 16'h0001 : 16'h0000;
    next_int_len = dev_int_oe ? int_len + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge i_clk_sys)
  begin
    rst_len <= next_rst_len;
    int_len <= next_int_len;
  end
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);
  sequence start_cond;
    scl && $fell(sda);
  endsequence
  sequence stop_cond;
    scl && $rose(sda);
  endsequence
  chk_reset_lines: assert property (disable iff (1'b0) !i_rst_b |=>
    !host_sda_oe && !host_rst_oe && !dev_sda_oe && !dev_int_oe) else $error("line held in reset");
  chk_rst_pulse_len: assert property ($fell(host_rst_oe) |->
    rst_len > 16'(`TSH_RST_US * `TSH_CLK_MHZ))
    else $error("reset pin pulse too short");
  chk_pin_hold: assert property (host_rst_oe [*8] |-> !dev_sda_oe && !dev_int_oe)
    else $error("device drives during pin reset");
  chk_pin_pullup: assert property (!host_rst_oe |-> rst_pin_n)
    else $error("reset pin low while undriven");
  chk_int_drain: assert property (int_n == !dev_int_oe)
    else $error("interrupt level wrong");
  chk_int_pulse_len: assert property ($fell(dev_int_oe) && rst_pin_n |->
    int_len >= `TSH_INT_PULSE_CYC) else $error("interrupt low too briefly");
  chk_dev_sda_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device moved data with clock high");
  chk_start_quiet: assert property (start_cond |->
    !dev_sda_oe throughout (##[1:100] $fell(scl))) else $error("device talks after start");
  chk_stop_idle: assert property (stop_cond |=> !dev_sda_oe [*4])
    else $error("device drives after stop");
endmodule

//--- verilog/tsh_defs.svh
// Shared register offsets, field values and timing counts for the touch sensor link
`ifndef TSH_DEFS_SVH
`define TSH_DEFS_SVH
`define TSH_REG_ID 8'h01
`define TSH_REG_FLAGS_LO 8'h02
`define TSH_REG_FLAGS_HI 8'h03
`define TSH_REG_CHEN_LO 8'h04
`define TSH_REG_CHEN_HI 8'h05
`define TSH_REG_LOCK 8'h0f
`define TSH_REG_CFG 8'h10
`define TSH_REG_IRQ_ST 8'h20
`define TSH_REG_IRQ_CLR 8'h21
`define TSH_REG_IRQ_EN 8'h22
`define TSH_BLANK 8'hff
`define TSH_ADDR_UPPER 4'hb
`define TSH_SEL_HIGH 3'h3
`define TSH_SEL_LOW 3'h0
`define TSH_CHEN_RST 16'h3fff
`define TSH_LOCK_OPEN 8'h5a
`define TSH_CFG_INT_BIT 4
`define TSH_CFG_MULTI_BIT 0
`define TSH_CLK_MHZ 100
`define TSH_INT_PULSE_NS 1000
`define TSH_INT_PULSE_CYC (`TSH_INT_PULSE_NS * `TSH_CLK_MHZ / 1000)
`define TSH_OPT_CYC 8
`define TSH_RST_US 10
`define TSH_RST_CYC (`TSH_RST_US * `TSH_CLK_MHZ + 1)
`define TSH_QTR_CYC 25
`define TSH_H_TARGET 4'h0
`define TSH_H_WDATA 4'h1
`define TSH_H_CTRL 4'h2
`define TSH_H_STATUS 4'h3
`define TSH_H_RDATA 4'h4
`define TSH_H_IRQ_ST 4'h5
`define TSH_H_IRQ_CLR 4'h6
`define TSH_H_IRQ_EN 4'h7
`define TSH_H_DSEL 4'h8
`endif

//--- verilog/tsh_dev.sv
// Touch sensor device: reset, touch flags, interrupt, option pin and serial target
// Summary of operation
// - Power-on reset holds all logic in reset
// - Low reset pin holds logic in reset
// - Host holds reset pin low over 10us
// - Reset pin pulled high internally when undriven
// - Each of 14 channels decides touch independently
// - Interrupt raised when flag registers change
// - Interrupt pin open drain, active low
// - Two interrupt behaviours chosen by config bit
// - Config bit clear pulse, set level
// - Option pin sampled after reset, then fixed
// - Board ties option pin firmly high or low
// - Option high gives select 011, low 000
// - Oscillator stops while both lines high
// - Controller sends address first after start
// - Address byte low bit selects direction
// - Control registers readable and writable, except interrupt clear, which is write-only
// - Touch flag one while touched, else zero
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "tsh_defs.svh"
module tsh_dev #(
  parameter int CHANNELS = 14
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  tsh_link_if.dev link,
  input wire logic [CHANNELS-1:0] i_sense_channel_inputs,
  output logic [CHANNELS-1:0] o_channel_touch_flag,
  output logic [2:0] o_device_select_bits,
  output logic o_osc_run,
  output logic o_in_reset
);
  // Pin order: 0 clock line, 1 data line, 2 reset pin, 3 option pin
  logic [3:0] s1, s2, s3, filt, prev;
  logic [3:0] next_s2, next_s3, next_filt;
  tsh_pkg::tsh_dev_state_t state, next_state;
  logic [3:0] bitcnt, next_bitcnt;
  logic [7:0] shift, next_shift, ptr, next_ptr;
  logic sda_oe, next_sda_oe, int_oe, next_int_oe;
  logic [15:0] chen, next_chen, flags, next_flags;
  logic [7:0] lock, next_lock;
  logic int_mode, next_int_mode, multi, next_multi;
  logic [1:0] irq_st, next_irq_st, irq_en, next_irq_en, clr, ev;
  logic [15:0] pulse_cnt, next_pulse_cnt;
  logic [3:0] opt_cnt, next_opt_cnt;
  logic [2:0] dsel, next_dsel;
  logic osc, next_osc, rst_int, next_rst_int;
  logic scl_rise, scl_fall, start_c, stop_c, wr_en;
  logic [7:0] rbyte, wbyte;

  always_comb
  begin
    next_s2 = s1;
    next_s3 = s2;
    for (int i = 0; i < 4; i++)
    begin
      next_filt[i] = (s2[i] == s3[i]) ? s3[i] : filt[i];
    end
    // Either reset source keeps everything below except the synchronisers in reset
    next_rst_int = !i_rst_b || !filt[2];
    scl_rise = filt[0] && !prev[0];
    scl_fall = !filt[0] && prev[0];
    start_c = filt[0] && prev[0] && !filt[1] && prev[1];
    stop_c = filt[0] && prev[0] && filt[1] && !prev[1];
    case (ptr)
      `TSH_REG_ID: rbyte = {`TSH_ADDR_UPPER, dsel, 1'b0};
      `TSH_REG_FLAGS_LO: rbyte = flags[7:0];
      `TSH_REG_FLAGS_HI: rbyte = flags[15:8];
      `TSH_REG_CHEN_LO: rbyte = chen[7:0];
      `TSH_REG_CHEN_HI: rbyte = chen[15:8];
      `TSH_REG_LOCK: rbyte = lock;
      `TSH_REG_CFG: rbyte = 8'(({7'h00, int_mode} << `TSH_CFG_INT_BIT) | {7'h00, multi});
      `TSH_REG_IRQ_ST: rbyte = {6'h00, irq_st};
      `TSH_REG_IRQ_EN: rbyte = {6'h00, irq_en};
      default: rbyte = `TSH_BLANK;
    endcase
    next_state = state;
    next_bitcnt = bitcnt;
    next_shift = shift;
    next_ptr = ptr;
    next_sda_oe = sda_oe;
    wr_en = 1'b0;
    wbyte = shift;
    if (start_c)
    begin
      // Address byte always follows a start
      next_state = tsh_pkg::TSH_ADDR;
      next_bitcnt = 4'h0;
      next_sda_oe = 1'b0;
    end
    else if (stop_c)
    begin
      next_state = tsh_pkg::TSH_IDLE;
      next_sda_oe = 1'b0;
    end
    else if (scl_rise)
    begin
      case (state)
        tsh_pkg::TSH_ADDR, tsh_pkg::TSH_PTR, tsh_pkg::TSH_WR:
        begin
          next_shift = {shift[6:0], filt[1]};
          next_bitcnt = bitcnt + 4'h1;
        end
        tsh_pkg::TSH_ACK_R:
        begin
          // Host not acknowledging ends the read burst
          if (filt[1])
          begin
            next_state = tsh_pkg::TSH_IDLE;
          end
        end
        default:
        begin
        end
      endcase
    end
    else if (scl_fall)
    begin
      case (state)
        tsh_pkg::TSH_ADDR:
        begin
          if (bitcnt == 4'h8)
          begin
            if (shift[7:1] == {`TSH_ADDR_UPPER, dsel})
            begin
              next_state = tsh_pkg::TSH_ACK_A;
              next_sda_oe = 1'b1;
            end
            else
            begin
              next_state = tsh_pkg::TSH_IDLE;
            end
          end
        end
        tsh_pkg::TSH_ACK_A:
        begin
          next_bitcnt = 4'h0;
          if (shift[0])
          begin
            // Read starts at the current pointer
            next_state = tsh_pkg::TSH_RD;
            next_shift = {rbyte[6:0], 1'b0};
            next_sda_oe = !rbyte[7];
            next_bitcnt = 4'h1;
          end
          else
          begin
            next_state = tsh_pkg::TSH_PTR;
            next_sda_oe = 1'b0;
          end
        end
        tsh_pkg::TSH_PTR:
        begin
          if (bitcnt == 4'h8)
          begin
            next_ptr = shift;
            next_state = tsh_pkg::TSH_ACK_P;
            next_sda_oe = 1'b1;
          end
        end
        tsh_pkg::TSH_WR:
        begin
          if (bitcnt == 4'h8)
          begin
            wr_en = 1'b1;
            next_ptr = ptr + 8'h01;
            next_state = tsh_pkg::TSH_ACK_W;
            next_sda_oe = 1'b1;
          end
        end
        tsh_pkg::TSH_ACK_P, tsh_pkg::TSH_ACK_W:
        begin
          next_state = tsh_pkg::TSH_WR;
          next_bitcnt = 4'h0;
          next_sda_oe = 1'b0;
        end
        tsh_pkg::TSH_RD:
        begin
          if (bitcnt == 4'h8)
          begin
            next_state = tsh_pkg::TSH_ACK_R;
            next_sda_oe = 1'b0;
            next_ptr = ptr + 8'h01;
          end
          else
          begin
            next_sda_oe = !shift[7];
            next_shift = {shift[6:0], 1'b0};
            next_bitcnt = bitcnt + 4'h1;
          end
        end
        tsh_pkg::TSH_ACK_R:
        begin
          next_state = tsh_pkg::TSH_RD;
          next_shift = {rbyte[6:0], 1'b0};
          next_sda_oe = !rbyte[7];
          next_bitcnt = 4'h1;
        end
        default:
        begin
          next_state = tsh_pkg::TSH_IDLE;
        end
      endcase
    end
    // Register writes; lock register stays writable so software can unlock
    next_chen = chen;
    next_lock = lock;
    next_int_mode = int_mode;
    next_multi = multi;
    next_irq_en = irq_en;
    clr = 2'h0;
    if (wr_en && (lock == `TSH_LOCK_OPEN || ptr == `TSH_REG_LOCK))
    begin
      case (ptr)
        `TSH_REG_CHEN_LO: next_chen[7:0] = wbyte;
        `TSH_REG_CHEN_HI: next_chen[15:8] = {2'h0, wbyte[5:0]};
        `TSH_REG_LOCK: next_lock = wbyte;
        `TSH_REG_CFG:
        begin
          next_int_mode = wbyte[`TSH_CFG_INT_BIT];
          next_multi = wbyte[`TSH_CFG_MULTI_BIT];
        end
        `TSH_REG_IRQ_CLR: clr = wbyte[1:0];
        `TSH_REG_IRQ_EN: next_irq_en = wbyte[1:0];
        default:
        begin
        end
      endcase
    end
    // Per-channel touch, gated by its enable
    next_flags = 16'h0000;
    next_flags[CHANNELS-1:0] = i_sense_channel_inputs & chen[CHANNELS-1:0];
    ev[0] = next_flags != flags;
    ev[1] = opt_cnt == 4'h0;
    // Event set wins over a clear in the same cycle
    next_irq_st = (irq_st & ~clr) | ev;
    next_pulse_cnt = (pulse_cnt != 16'h0000) ? pulse_cnt - 16'h0001 : 16'h0000;
    if (|(ev & irq_en))
    begin
      next_pulse_cnt = 16'(`TSH_INT_PULSE_CYC);
    end
    // Only ever pulls low mode bit picks level or pulse
    if (int_mode)
    begin
      next_int_oe = |(next_irq_st & irq_en);
    end
    else
    begin
      next_int_oe = next_pulse_cnt != 16'h0000;
    end
    // Option pin watched a few cycles after reset, then frozen
    next_opt_cnt = opt_cnt;
    next_dsel = dsel;
    if (opt_cnt != 4'(`TSH_OPT_CYC))
    begin
      next_opt_cnt = opt_cnt + 4'h1;
      next_dsel = filt[3] ? `TSH_SEL_HIGH : `TSH_SEL_LOW;
    end
    // Both lines high idles the oscillator; any fall restarts it
    next_osc = !(filt[0] && filt[1]);
  end

  // Synchronisers only see the power-on reset so the reset pin is still watched
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      s1 <= 4'hf; // Undriven reset pin reads inactive
      s2 <= 4'hf;
      s3 <= 4'hf;
      filt <= 4'hf;
      prev <= 4'hf;
      rst_int <= 1'b1;
    end
    else
    begin
      s1 <= {link.opt_pin, link.rst_pin_n, link.sda, link.scl};
      s2 <= next_s2;
      s3 <= next_s3;
      filt <= next_filt;
      prev <= filt;
      rst_int <= next_rst_int;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b || rst_int)
    begin
      state <= tsh_pkg::TSH_IDLE;
      bitcnt <= 4'h0;
      shift <= 8'h00;
      ptr <= 8'h00;
      sda_oe <= 1'b0;
      int_oe <= 1'b0;
      chen <= `TSH_CHEN_RST;
      flags <= 16'h0000;
      lock <= `TSH_LOCK_OPEN;
      int_mode <= 1'b1;
      multi <= 1'b1;
      irq_st <= 2'h0;
      irq_en <= 2'h0;
      pulse_cnt <= 16'h0000;
      opt_cnt <= 4'h0;
      dsel <= `TSH_SEL_LOW;
      osc <= 1'b0;
    end
    else
    begin
      state <= next_state;
      bitcnt <= next_bitcnt;
      shift <= next_shift;
      ptr <= next_ptr;
      sda_oe <= next_sda_oe;
      int_oe <= next_int_oe;
      chen <= next_chen;
      flags <= next_flags;
      lock <= next_lock;
      int_mode <= next_int_mode;
      multi <= next_multi;
      irq_st <= next_irq_st;
      irq_en <= next_irq_en;
      pulse_cnt <= next_pulse_cnt;
      opt_cnt <= next_opt_cnt;
      dsel <= next_dsel;
      osc <= next_osc;
    end
  end

  assign link.dev_sda_oe = sda_oe;
  assign link.dev_int_oe = int_oe;
  assign o_channel_touch_flag = flags[CHANNELS-1:0];
  assign o_device_select_bits = dsel;
  assign o_osc_run = osc;
  assign o_in_reset = rst_int;
endmodule

//--- verilog/tsh_host.sv
// Host controller: register port in, serial controller and reset pin out
`timescale 1ns/10ps
`include "tsh_defs.svh"
module tsh_host #(
  parameter int QTR_CYC = `TSH_QTR_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  tsh_link_if.host link,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_irq
);
  logic [1:0] s1, s2, s3, filt, prev, next_filt;
  logic [7:0] target, wdata, rdata, dout, rx;
  logic [2:0] dsel;
  logic busy, is_read, nack, scl_oe, sda_oe, irq;
  logic [2:0] irq_st, irq_en;
  logic [3:0] step, bitn;
  logic [1:0] q;
  logic [15:0] div, rst_cnt;
  logic [7:0] next_target, next_wdata, next_rdata, next_dout, next_rx, txb;
  logic [2:0] next_dsel, next_irq_st, next_irq_en, ev, clr;
  logic next_busy, next_is_read, next_nack, next_scl_oe, next_sda_oe, next_irq, tick;
  logic [3:0] next_step, next_bitn;
  logic [1:0] next_q;
  logic [15:0] next_div, next_rst_cnt;
  tsh_pkg::tsh_act_t act;
  logic rst_oe, next_rst_oe;

  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      next_filt[i] = (s2[i] == s3[i]) ? s3[i] : filt[i];
    end
    // Sequence: start, address write, pointer, then data or stop and read back
    act = tsh_pkg::TSH_ACT_TX;
    txb = {`TSH_ADDR_UPPER, dsel, 1'b0};
    case (step)
      4'h0, 4'h4: act = is_read ? tsh_pkg::TSH_ACT_START : (step == 4'h0 ?
        tsh_pkg::TSH_ACT_START : tsh_pkg::TSH_ACT_STOP);
      4'h2: txb = target;
      4'h3: act = is_read ? tsh_pkg::TSH_ACT_STOP : tsh_pkg::TSH_ACT_TX;
      4'h5: act = is_read ? tsh_pkg::TSH_ACT_TX : tsh_pkg::TSH_ACT_DONE;
      4'h6: act = tsh_pkg::TSH_ACT_RX;
      4'h7: act = tsh_pkg::TSH_ACT_STOP;
      4'h8: act = tsh_pkg::TSH_ACT_DONE;
      default: act = tsh_pkg::TSH_ACT_TX;
    endcase
    if (step == 4'h3 && !is_read)
    begin
      txb = wdata;
    end
    if (step == 4'h5)
    begin
      txb = {`TSH_ADDR_UPPER, dsel, 1'b1};
    end
    next_target = target;
    next_wdata = wdata;
    next_dsel = dsel;
    next_irq_en = irq_en;
    next_busy = busy;
    next_is_read = is_read;
    next_nack = nack;
    next_step = step;
    next_bitn = bitn;
    next_q = q;
    next_scl_oe = scl_oe;
    next_sda_oe = sda_oe;
    next_rx = rx;
    next_rdata = rdata;
    clr = 3'h0;
    ev = 3'h0;
    next_rst_cnt = (rst_cnt != 16'h0000) ? rst_cnt - 16'h0001 : 16'h0000;
    if (i_wr)
    begin
      case (i_addr)
        `TSH_H_TARGET: next_target = i_wdata;
        `TSH_H_WDATA: next_wdata = i_wdata;
        `TSH_H_DSEL: next_dsel = i_wdata[2:0];
        `TSH_H_IRQ_CLR: clr = i_wdata[2:0];
        `TSH_H_IRQ_EN: next_irq_en = i_wdata[2:0];
        `TSH_H_CTRL:
        begin
          if (!busy && (i_wdata[0] || i_wdata[1]))
          begin
            next_busy = 1'b1;
            next_is_read = i_wdata[1];
            next_nack = 1'b0;
            next_step = 4'h0;
            next_bitn = 4'h0;
            next_q = 2'h0;
          end
          if (i_wdata[2])
          begin
            next_rst_cnt = 16'(`TSH_RST_CYC);
          end
        end
        default:
        begin
        end
      endcase
    end
    next_rst_oe = next_rst_cnt != 16'h0000;
    next_dout = 8'h00;
    case (i_addr)
      `TSH_H_TARGET: next_dout = target;
      `TSH_H_WDATA: next_dout = wdata;
      `TSH_H_STATUS: next_dout = {5'h00, filt[1], nack, busy};
      `TSH_H_RDATA: next_dout = rdata;
      `TSH_H_IRQ_ST: next_dout = {5'h00, irq_st};
      `TSH_H_IRQ_EN: next_dout = {5'h00, irq_en};
      `TSH_H_DSEL: next_dout = {5'h00, dsel};
      default: next_dout = 8'h00;
    endcase
    if (!i_rd)
    begin
      next_dout = 8'h00;
    end
    tick = div == 16'(QTR_CYC - 1);
    next_div = (tick || !busy) ? 16'h0000 : div + 16'h0001;
    if (busy && tick)
    begin
      next_q = q + 2'h1;
      case (act)
        tsh_pkg::TSH_ACT_START:
        begin
          if (q == 2'h1)
          begin
            next_sda_oe = 1'b1;
          end
          if (q == 2'h2)
          begin
            next_scl_oe = 1'b1;
          end
        end
        tsh_pkg::TSH_ACT_STOP:
        begin
          // Clock left high after the stop so the bus really idles
          next_scl_oe = q == 2'h0;
          next_sda_oe = q != 2'h2 && q != 2'h3;
        end
        tsh_pkg::TSH_ACT_DONE:
        begin
          next_busy = 1'b0;
          next_rdata = rx;
          ev[0] = 1'b1;
        end
        default:
        begin
          if (q == 2'h0)
          begin
            next_scl_oe = 1'b1;
            // Receive byte ends with no acknowledge to close the read
            next_sda_oe = act == tsh_pkg::TSH_ACT_TX && bitn != 4'h8 && !txb[3'(4'h7 - bitn)];
          end
          if (q == 2'h1)
          begin
            next_scl_oe = 1'b0;
          end
          if (q == 2'h2 && bitn != 4'h8)
          begin
            next_rx = {rx[6:0], filt[0]};
          end
          if (q == 2'h2 && bitn == 4'h8 && act == tsh_pkg::TSH_ACT_TX && filt[0])
          begin
            next_nack = 1'b1;
            ev[1] = 1'b1;
          end
        end
      endcase
      if (q == 2'h3)
      begin
        next_bitn = (act == tsh_pkg::TSH_ACT_TX || act == tsh_pkg::TSH_ACT_RX) &&
          bitn != 4'h8 ? bitn + 4'h1 : 4'h0;
        if (next_bitn == 4'h0)
        begin
          next_step = step + 4'h1;
        end
      end
    end
    ev[2] = !filt[1] && prev[1];
    next_irq_st = (irq_st & ~clr) | ev;
    next_irq = |(next_irq_st & irq_en);
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      s1 <= 2'h3;
      s2 <= 2'h3;
      s3 <= 2'h3;
      filt <= 2'h3;
      prev <= 2'h3;
      target <= 8'h00;
      wdata <= 8'h00;
      rdata <= 8'h00;
      dout <= 8'h00;
      rx <= 8'h00;
      dsel <= `TSH_SEL_LOW;
      busy <= 1'b0;
      is_read <= 1'b0;
      nack <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      irq <= 1'b0;
      irq_st <= 3'h0;
      irq_en <= 3'h0;
      step <= 4'h0;
      bitn <= 4'h0;
      q <= 2'h0;
      div <= 16'h0000;
      rst_cnt <= 16'h0000;
      rst_oe <= 1'b0;
    end
    else
    begin
      s1 <= {link.int_n, link.sda};
      s2 <= s1;
      s3 <= s2;
      filt <= next_filt;
      prev <= filt;
      target <= next_target;
      wdata <= next_wdata;
      rdata <= next_rdata;
      dout <= next_dout;
      rx <= next_rx;
      dsel <= next_dsel;
      busy <= next_busy;
      is_read <= next_is_read;
      nack <= next_nack;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
      irq <= next_irq;
      irq_st <= next_irq_st;
      irq_en <= next_irq_en;
      step <= next_step;
      bitn <= next_bitn;
      q <= next_q;
      div <= next_div;
      rst_cnt <= next_rst_cnt;
      rst_oe <= next_rst_oe;
    end
  end

  assign link.host_scl_oe = scl_oe;
  assign link.host_sda_oe = sda_oe;
  assign link.host_rst_oe = rst_oe;
  assign o_rdata = dout;
  assign o_irq = irq;
endmodule

//--- verilog/tsh_link_if.sv
// Pins between the host controller and the touch sensor, with wire resolution
`timescale 1ns/10ps
interface tsh_link_if;
  logic host_scl_oe;
  logic host_sda_oe;
  logic host_rst_oe;
  logic dev_sda_oe;
  logic dev_int_oe;
  logic opt_pin;
  logic scl;
  logic sda;
  logic int_n;
  logic rst_pin_n;
  // Open drain everywhere; pull-ups make an undriven wire read high
  assign scl = !host_scl_oe;
  assign sda = !(host_sda_oe || dev_sda_oe);
  assign int_n = !dev_int_oe;
  assign rst_pin_n = !host_rst_oe;
  modport dev (input scl, input sda, input rst_pin_n, input opt_pin,
    output dev_sda_oe, output dev_int_oe);
  modport host (input scl, input sda, input int_n,
    output host_scl_oe, output host_sda_oe, output host_rst_oe);
endinterface

//--- verilog/tsh_pkg.sv
// Types shared by both ends of the touch sensor link
package tsh_pkg;
  typedef enum logic [3:0] {
    TSH_IDLE = 4'h0,
    TSH_ADDR = 4'h1,
    TSH_ACK_A = 4'h3,
    TSH_PTR = 4'h2,
    TSH_ACK_P = 4'h6,
    TSH_WR = 4'h7,
    TSH_ACK_W = 4'h5,
    TSH_RD = 4'h4,
    TSH_ACK_R = 4'hc
  } tsh_dev_state_t;
  typedef enum logic [2:0] {
    TSH_ACT_START = 3'h0,
    TSH_ACT_TX = 3'h1,
    TSH_ACT_RX = 3'h3,
    TSH_ACT_STOP = 3'h2,
    TSH_ACT_DONE = 3'h6
  } tsh_act_t;
endpackage
